/* File: cap_map.svh */
// register map, field layout and bus constants of the current-limit bank
`ifndef CAP_MAP_SVH
`define CAP_MAP_SVH
`define CMD_CHARGE_CAP 8'h14
`define CMD_INPUT_CAP_PRIMARY 8'h3f
`define CMD_INPUT_CAP_SECONDARY 8'h3b
`define SLAVE_ADDR 7'h09
`define CAP_FIELD_W 11
`define CAP_FIELD_LSB 2
`define CAP_FIELD_MSB 12
`define CAP_FIELD_MAX 11'h5f0
`define CHARGE_CAP_RESET 11'h000
`define PRIMARY_CAP_RESET 11'h000
`define SECONDARY_CAP_DEFAULT 11'h177
`define BYTE_BITS 4'h8
`define SYNC_IDLE 15'h6000
`endif

/* File: cap_pkg.sv */
// types and the clamp helper shared by the current-limit bank
package cap_pkg;
`include "cap_map.svh"

  typedef logic [`CAP_FIELD_W-1:0] cap_field_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_RLO, ST_RHI, ST_SKIP
  } smbus_state_type;

  function automatic cap_field_type clampField(input cap_field_type v);
    return (v > `CAP_FIELD_MAX) ? `CAP_FIELD_MAX : v;
  endfunction : clampField

endpackage : cap_pkg

/* File: current_limit_register_bank.sv */
// charge and input current-limit registers behind an SMBus word slave
`timescale 1ns/10ps
`include "cap_map.svh"
module current_limit_register_bank
  import cap_pkg::*;
#(
  parameter int FIELD_W = `CAP_FIELD_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // smbus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // adapter power-on and strap inputs
  input wire logic adapterPorIn,
  input wire logic batteryFirstIn,
  input wire logic [FIELD_W-1:0] strapCodeIn,
  // limits towards the regulation loop
  output logic [FIELD_W-1:0] chargeCapField,
  output logic [FIELD_W-1:0] inputCapPrimaryField,
  output logic [FIELD_W-1:0] inputCapSecondaryField
);

  if (FIELD_W != `CAP_FIELD_W) begin : g_bad_field
    $error("current_limit_register_bank serves an 11-bit field only");
  end

  logic [FIELD_W+3:0] syncBus;
  logic sclS;
  logic sdaS;
  logic adpPor;
  logic batFirst;
  cap_field_type strapS;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  smbus_state_type state_r;
  logic [3:0] bitCnt_r;
  logic ackSlot_r;
  logic masterAck_r;
  logic [7:0] shift_r;
  logic [7:0] cmd_r;
  logic [7:0] loByte_r;
  logic sdaOe_r;
  logic txState;
  logic byteDone;
  logic wrEn;
  cap_field_type wrField;
  cap_field_type chargeCap_r;
  cap_field_type primaryCap_r;
  cap_field_type secondaryCap_r;
  cap_field_type readField;
  logic [15:0] readWord;

  sync_agree #(
    .WIDTH(FIELD_W + 4),
    .RESET_VAL(`SYNC_IDLE)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({sclIn, sdaIn, adapterPorIn, batteryFirstIn, strapCodeIn}),
    .syncOut(syncBus)
  );

  assign {sclS, sdaS, adpPor, batFirst, strapS} = syncBus;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  assign startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
  assign stopCond = sclS && sclPrev_r && !sdaPrev_r && sdaS;
  assign sclRise = sclS && !sclPrev_r;
  assign sclFall = !sclS && sclPrev_r;
  assign txState = (state_r == ST_RLO) || (state_r == ST_RHI);
  assign byteDone = sclFall && !ackSlot_r && (bitCnt_r == `BYTE_BITS);
  assign wrEn = byteDone && (state_r == ST_WHI);
  // only bits 12:2 of the word survive; same code for either sense resistor
  // word bits 12:8 come from the high byte, 7:2 from the low byte
  assign wrField = clampField({shift_r[4:0], loByte_r[7:2]});

  // unknown commands read as zero rather than aliasing a real register
  always_comb begin
    case (cmd_r)
      `CMD_CHARGE_CAP: readField = chargeCap_r;
      `CMD_INPUT_CAP_PRIMARY: readField = primaryCap_r;
      `CMD_INPUT_CAP_SECONDARY: readField = secondaryCap_r;
      default: readField = '0;
    endcase
    readWord = {3'h0, readField, 2'h0};
  end

  always_ff @(posedge clk) begin : smbus_fsm
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      ackSlot_r <= 1'b0;
      masterAck_r <= 1'b0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      loByte_r <= 8'h00;
      sdaOe_r <= 1'b0;
    end else if (startCond) begin
      state_r <= ST_ADDR;
      bitCnt_r <= 4'h0;
      ackSlot_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (stopCond) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      ackSlot_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (sclRise) begin
      if (ackSlot_r) begin
        masterAck_r <= !sdaS;
      end else if (bitCnt_r != `BYTE_BITS && state_r != ST_IDLE &&
                   state_r != ST_SKIP) begin
        bitCnt_r <= bitCnt_r + 4'h1;
        if (!txState) begin
          shift_r <= {shift_r[6:0], sdaS};
        end
      end
    end else if (sclFall) begin
      if (ackSlot_r) begin
        ackSlot_r <= 1'b0;
        bitCnt_r <= 4'h0;
        sdaOe_r <= 1'b0;
        case (state_r)
          ST_ADDR: begin
            if (shift_r[0]) begin
              state_r <= ST_RLO;
              shift_r <= readWord[7:0];
              sdaOe_r <= !readWord[7];
            end else begin
              state_r <= ST_CMD;
            end
          end
          ST_CMD: state_r <= ST_WLO;
          ST_WLO: state_r <= ST_WHI;
          ST_RLO: begin
            if (masterAck_r) begin
              state_r <= ST_RHI;
              shift_r <= readWord[15:8];
              sdaOe_r <= !readWord[15];
            end else begin
              state_r <= ST_SKIP;
            end
          end
          default: state_r <= ST_SKIP;
        endcase
      end else if (bitCnt_r == `BYTE_BITS) begin
        case (state_r)
          ST_ADDR: begin
            if (shift_r[7:1] == `SLAVE_ADDR) begin
              ackSlot_r <= 1'b1;
              sdaOe_r <= 1'b1;
            end else begin
              state_r <= ST_SKIP;
            end
          end
          ST_CMD: begin
            cmd_r <= shift_r;
            ackSlot_r <= 1'b1;
            sdaOe_r <= 1'b1;
          end
          ST_WLO: begin
            loByte_r <= shift_r;
            ackSlot_r <= 1'b1;
            sdaOe_r <= 1'b1;
          end
          ST_WHI: begin
            ackSlot_r <= 1'b1;
            sdaOe_r <= 1'b1;
          end
          ST_RLO, ST_RHI: begin
            ackSlot_r <= 1'b1;
            sdaOe_r <= 1'b0;
          end
          default: state_r <= ST_SKIP;
        endcase
      end else if (txState) begin
        sdaOe_r <= !shift_r[6];
        shift_r <= {shift_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin : charge_cap
    if (!rst_n) begin
      chargeCap_r <= `CHARGE_CAP_RESET;
    end else if (wrEn && cmd_r == `CMD_CHARGE_CAP) begin
      chargeCap_r <= wrField;
    end
  end

  // adapter power-on outranks a bus write landing in the same cycle
  always_ff @(posedge clk) begin : primary_cap
    if (!rst_n) begin
      primaryCap_r <= `PRIMARY_CAP_RESET;
    end else if (adpPor) begin
      primaryCap_r <= clampField(strapS);
    end else if (wrEn && cmd_r == `CMD_INPUT_CAP_PRIMARY) begin
      primaryCap_r <= wrField;
    end
  end

  always_ff @(posedge clk) begin : secondary_cap
    if (!rst_n) begin
      secondaryCap_r <= `SECONDARY_CAP_DEFAULT;
    end else if (adpPor && !batFirst) begin
      secondaryCap_r <= `SECONDARY_CAP_DEFAULT;
    end else if (!adpPor && wrEn && cmd_r == `CMD_INPUT_CAP_SECONDARY) begin
      secondaryCap_r <= wrField;
    end
  end

  // open drain: the pad only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_r;
  assign chargeCapField = chargeCap_r;
  assign inputCapPrimaryField = primaryCap_r;
  assign inputCapSecondaryField = secondaryCap_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence addrMatch;
    state_r == ST_ADDR && byteDone && shift_r[7:1] == `SLAVE_ADDR;
  endsequence

  sequence readStart;
    state_r == ST_ADDR && ackSlot_r && sclFall && shift_r[0] &&
      !startCond && !stopCond;
  endsequence

  a_addr_ack: assert property (addrMatch |=> sdaOe_r && ackSlot_r ##0
    (sdaOe_r throughout (!sclFall [*1])))
    else $error("own address not acknowledged");
  a_cmd_ack: assert property (state_r == ST_CMD && byteDone |=>
    sdaOe_r && cmd_r == $past(shift_r))
    else $error("command byte not acknowledged or not kept");
  a_read_lofirst: assert property (readStart |=> state_r == ST_RLO &&
    shift_r == $past(readWord[7:0]) && sdaOe_r == !shift_r[7])
    else $error("read did not start with the low byte msb");
  a_charge_write: assert property (wrEn && cmd_r == `CMD_CHARGE_CAP |=>
    chargeCapField == clampField({$past(shift_r[4:0]), $past(loByte_r[7:2])}))
    else $error("charge cap write not stored clamped");
  a_charge_clamp: assert property (chargeCap_r <= `CAP_FIELD_MAX &&
    primaryCap_r <= `CAP_FIELD_MAX && secondaryCap_r <= `CAP_FIELD_MAX)
    else $error("stored cap above the clamp");
  a_por_clear: assert property ($rose(rst_n) |->
    chargeCapField == `CHARGE_CAP_RESET)
    else $error("charge cap not cleared by reset");
  a_unused_zero: assert property (readWord[1:0] == 2'h0 &&
    readWord[15:13] == 3'h0)
    else $error("unused read bits not zero");
  a_strap_load: assert property (adpPor |=>
    inputCapPrimaryField == clampField($past(strapS)))
    else $error("primary cap not loaded from strap");
  a_sec_default: assert property (adpPor && !batFirst |=>
    inputCapSecondaryField == `SECONDARY_CAP_DEFAULT)
    else $error("secondary cap not defaulted");
  a_sec_keep: assert property (adpPor && batFirst |=>
    $stable(inputCapSecondaryField))
    else $error("secondary cap lost with battery first");
  a_read_back: assert property (cmd_r == `CMD_INPUT_CAP_PRIMARY |->
    readWord[12:2] == primaryCap_r)
    else $error("primary cap read back wrong");

endmodule : current_limit_register_bank

/* File: current_limit_register_bank_bench.sv */
// self-checking bench for the current-limit register bank
`timescale 1ns/10ps
module current_limit_register_bank_bench import cap_pkg::*;;
  logic clk, rst_n, scl, sdaDrv, sdaOut, sdaOe, sdaWire;
  logic adapterPor, batteryFirst, ack;
  cap_field_type strapCode, chargeCap, inPri, inSec;
  cap_field_type expd [3];
  logic [15:0] r, w;
  logic [7:0] cmds [3] = '{8'h14, 8'h3f, 8'h3b};
  int badCount = 0;
  int numChecks = 0;

  // open-drain wire with pull-up
  assign sdaWire = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;

  current_limit_register_bank dut (.clk(clk), .rst_n(rst_n), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .adapterPorIn(adapterPor), .batteryFirstIn(batteryFirst),
    .strapCodeIn(strapCode), .chargeCapField(chargeCap),
    .inputCapPrimaryField(inPri), .inputCapSecondaryField(inSec));

  smbus_host_model host (.clk(clk), .scl(scl), .sdaDrv(sdaDrv),
    .sdaWire(sdaWire));

  function automatic cap_field_type expField(input logic [15:0] v);
    return (v[12:2] > 11'h5f0) ? 11'h5f0 : v[12:2];
  endfunction : expField

  function automatic cap_field_type fieldOf(input int c);
    return (c == 0) ? chargeCap : (c == 1) ? inPri : inSec;
  endfunction : fieldOf

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (badCount == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    adapterPor = 1'b0;
    batteryFirst = 1'b0;
    strapCode = '0;
    void'($urandom(70925));
    host.tick(12);
    rst_n = 1'b1;
    check(16'(chargeCap), 16'h0);
    check(16'(inSec), 16'h177);
    // saturating, just-at-max, just-over-max and random words per register
    foreach (cmds[c]) begin
      for (int k = 0; k < 4; k++) begin
        w = (k == 0) ? 16'hffff : (k == 1) ? 16'h17c0 :
            (k == 2) ? 16'h17c4 : 16'($urandom);
        host.writeWord(8'h12, cmds[c], w, ack);
        expd[c] = expField(w);
        check(16'(ack), 16'h0);
        check(16'(fieldOf(c)), 16'(expd[c]));
        host.readWord(cmds[c], r);
        check(r, {3'h0, expd[c], 2'h0});
      end
    end
    // a foreign address is neither acked nor written
    host.writeWord(8'h14, 8'h14, 16'h0000, ack);
    check(16'(ack), 16'h1);
    check(16'(chargeCap), 16'(expd[0]));
    host.readWord(8'h15, r);
    check(r, 16'h0000);
    strapCode = 11'($urandom);
    adapterPor = 1'b1;
    host.tick(10);
    check(16'(inPri), 16'(expField({3'h0, strapCode, 2'h0})));
    check(16'(inSec), 16'h177);
    adapterPor = 1'b0;
    host.tick(10);
    host.writeWord(8'h12, 8'h3b, 16'h1000, ack);
    batteryFirst = 1'b1;
    adapterPor = 1'b1;
    host.tick(10);
    check(16'(inSec), 16'h400);
    adapterPor = 1'b0;
    rst_n = 1'b0;
    host.tick(12);
    rst_n = 1'b1;
    check(16'(chargeCap), 16'h0);
    end_of_test();
  end
endmodule : current_limit_register_bank_bench

/* File: smbus_host_model.sv */
// smbus host model issuing word writes and word reads
`timescale 1ns/10ps
module smbus_host_model (
  // clock
  input wire logic clk,
  // bus lines, released drive means the pull-up wins
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // sda moves only while scl is low, well clear of the synchronised fall
  task automatic bitIo(input logic b, output logic s);
    tick(6);
    sdaDrv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    s = sdaWire;
    tick(4);
    scl = 1'b0;
  endtask : bitIo

  // also serves as repeated start from a low scl
  task automatic start();
    tick(6);
    sdaDrv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sdaDrv = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    tick(6);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sdaDrv = 1'b1;
    tick(8);
  endtask : stop

  // eight bits msb first, then the ninth bit; r holds what the wire showed
  task automatic byteIo(input logic [7:0] v, input logic last,
                        output logic [7:0] r, output logic ninth);
    for (int i = 7; i >= 0; i--) bitIo(v[i], r[i]);
    bitIo(last, ninth);
  endtask : byteIo

  task automatic writeWord(input logic [7:0] addrW, input logic [7:0] cmd,
                           input logic [15:0] w, output logic ack);
    logic [7:0] r;
    logic n;
    start();
    byteIo(addrW, 1'b1, r, ack);
    byteIo(cmd, 1'b1, r, n);
    byteIo(w[7:0], 1'b1, r, n);
    byteIo(w[15:8], 1'b1, r, n);
    stop();
  endtask : writeWord

  task automatic readWord(input logic [7:0] cmd, output logic [15:0] w);
    logic [7:0] r;
    logic n;
    start();
    byteIo(8'h12, 1'b1, r, n);
    byteIo(cmd, 1'b1, r, n);
    start();
    byteIo(8'h13, 1'b1, r, n);
    byteIo(8'hff, 1'b0, w[7:0], n);
    byteIo(8'hff, 1'b1, w[15:8], n);
    stop();
  endtask : readWord
endmodule : smbus_host_model

/* File: sync_agree.sv */
// three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
module sync_agree #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous side
  input wire logic [WIDTH-1:0] asyncIn,
  // synchronous side
  output logic [WIDTH-1:0] syncOut
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_agree needs WIDTH of at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic agreed_r;
    // one process per bit owns its own flop; the port bit just follows it
    assign syncOut[i] = agreed_r;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        stage1_r <= RESET_VAL[i];
        stage2_r <= RESET_VAL[i];
        stage3_r <= RESET_VAL[i];
        agreed_r <= RESET_VAL[i];
      end else begin
        stage1_r <= asyncIn[i];
        stage2_r <= stage1_r;
        stage3_r <= stage2_r;
        // a one-cycle glitch between stages two and three is filtered
        if (stage2_r == stage3_r) begin
          agreed_r <= stage3_r;
        end
      end
    end
  end

endmodule : sync_agree
